/* File: lmrs_pkg.sv */
package lmrs_pkg;
  localparam int          CLK_HZ            = 25000000;
  localparam int          DWELL_TIME_NS     = 320000;
  localparam int          DWELL_CYCLES      = (DWELL_TIME_NS / 1000) * (CLK_HZ / 1000000);
  localparam int          NUM_ROWS          = 8;
  localparam logic [3:0]  DEV_ADDR_RESET    = 4'h0;
  localparam logic [3:0]  CTRL_PREFIX       = 4'h0;
  localparam logic [7:0]  PATTERN_BASE      = 8'hD0;
  localparam logic [7:0]  RING_RESET        = 8'hFE;
  localparam logic [63:0] INIT_CHARACTER    = 64'h00_41_41_7F_41_41_22_1C;

  typedef struct packed {
    logic       we;
    logic [2:0] waddr;
    logic [7:0] wdata;
    logic [2:0] raddr;
  } lmrs_mem_req_t;

  typedef struct packed {
    logic scl_o;
    logic scl_oe;
    logic sda_o;
    logic sda_oe;
  } lmrs_i2c_drv_t;

  typedef enum logic [2:0] {
    I2C_IDLE  = 3'b000,
    I2C_CTRL  = 3'b001,
    I2C_WADDR = 3'b010,
    I2C_DATA  = 3'b011,
    I2C_ACK   = 3'b100,
    I2C_READ  = 3'b101,
    I2C_RACK  = 3'b110,
    I2C_SKIP  = 3'b111
  } lmrs_i2c_state_t;
endpackage : lmrs_pkg

/* File: lmrs_pattern_mem.sv */
`timescale 1ns/1ns
module lmrs_pattern_mem
  import lmrs_pkg::*;
#(
  parameter int DEPTH = 8
) (
  input  wire logic                i_clk,
  input  wire logic                i_sys_rst,
  input  wire lmrs_pkg::lmrs_mem_req_t i_req,
  input  wire logic [2:0]          i_raddr2,
  output logic      [7:0]          o_rdata,
  output logic      [7:0]          o_rdata2
);
  logic [7:0] mem_reg [DEPTH];
  logic [7:0] rdata_reg;
  logic [7:0] rdata2_reg;

  // Preset character reloads on reset so the matrix never starts blank
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      for (int k = 0; k < DEPTH; k++) begin
        mem_reg[k] <= INIT_CHARACTER[k*8 +: 8];
      end
      rdata_reg  <= 8'h00;
      rdata2_reg <= 8'h00;
    end else begin
      if (i_req.we) begin
        mem_reg[i_req.waddr] <= i_req.wdata;
      end
      rdata_reg  <= mem_reg[i_req.raddr];
      rdata2_reg <= mem_reg[i_raddr2];
    end
  end

  assign o_rdata  = rdata_reg;
  assign o_rdata2 = rdata2_reg;
endmodule : lmrs_pattern_mem

/* File: lmrs_scanner.sv */
`timescale 1ns/1ns
module lmrs_scanner
  import lmrs_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic       i_sys_rst,
  input  wire logic       i_sequencer_reset_n,
  input  wire logic       i_scl,
  input  wire logic       i_sda,
  output logic            o_sda_o,
  output logic            o_sda_oe,
  output logic      [6:0] o_col,
  output logic      [7:0] o_row_n
);
  function automatic logic [2:0] slot_of(input logic [7:0] a);
    return a[2:0];
  endfunction : slot_of

  function automatic logic hit(input logic [7:0] a);
    return (a[7:3] == PATTERN_BASE[7:3]);
  endfunction : hit

  // Bus front end: edges and start/stop from prior samples
  logic scl_d_reg, sda_d_reg;
  wire  scl_rise = i_scl & ~scl_d_reg;
  wire  scl_fall = ~i_scl & scl_d_reg;
  wire  start_c  = scl_d_reg & i_scl & sda_d_reg & ~i_sda;
  wire  stop_c   = scl_d_reg & i_scl & ~sda_d_reg & i_sda;

  lmrs_i2c_state_t st_reg, st_next, ret_reg, ret_next;
  logic [7:0] sh_reg, sh_next, wa_reg, wa_next, tx_reg, tx_next;
  logic [3:0] bit_reg, bit_next;
  logic       ack_reg, ack_next, sda_oe_reg, sda_oe_next, rd_reg, rd_next;
  logic [3:0] dev_addr_reg;
  logic       we;
  logic [7:0] mem_rdata, pat_rdata;
  lmrs_mem_req_t req;

  always_comb begin
    st_next = st_reg; ret_next = ret_reg; sh_next = sh_reg; wa_next = wa_reg;
    tx_next = tx_reg; bit_next = bit_reg; ack_next = ack_reg;
    sda_oe_next = sda_oe_reg; rd_next = rd_reg; we = 1'b0;
    if (start_c) begin
      st_next = I2C_CTRL; bit_next = 4'h0; sda_oe_next = 1'b0;
    end else if (stop_c) begin
      st_next = I2C_IDLE; sda_oe_next = 1'b0;
    end else begin
      case (st_reg)
        I2C_CTRL, I2C_WADDR, I2C_DATA: begin
          if (scl_rise) begin
            sh_next = {sh_reg[6:0], i_sda};
            bit_next = bit_reg + 4'h1;
          end else if (scl_fall && bit_reg == 4'h8) begin
            bit_next = 4'h0;
            ret_next = I2C_SKIP;
            ack_next = 1'b1;
            if (st_reg == I2C_CTRL) begin
              // Only our address answers; anything else is left alone
              if (sh_reg[7:4] == CTRL_PREFIX && sh_reg[3:1] == dev_addr_reg[3:1]) begin
                rd_next  = sh_reg[0];
                ret_next = sh_reg[0] ? I2C_READ : I2C_WADDR;
              end else begin
                ack_next = 1'b0;
              end
            end else if (st_reg == I2C_WADDR) begin
              wa_next = sh_reg; ret_next = I2C_DATA;
            end else begin
              // Extra data bytes past the one allowed are not acknowledged
              we = hit(wa_reg);
              ret_next = I2C_SKIP;
            end
            sda_oe_next = ack_next;
            st_next = I2C_ACK;
          end
        end
        I2C_ACK: if (scl_fall) begin
          sda_oe_next = 1'b0; st_next = ret_reg;
          if (ret_reg == I2C_READ) begin
            tx_next = hit(wa_reg) ? mem_rdata : 8'h00;
            sda_oe_next = ~(hit(wa_reg) ? mem_rdata[7] : 1'b0);
          end
        end
        I2C_READ: if (scl_fall) begin
          if (bit_reg == 4'h7) begin
            bit_next = 4'h0; sda_oe_next = 1'b0; st_next = I2C_RACK;
          end else begin
            bit_next = bit_reg + 4'h1;
            tx_next = {tx_reg[6:0], 1'b0};
            sda_oe_next = ~tx_reg[6];
          end
        end
        I2C_RACK: if (scl_rise) st_next = i_sda ? I2C_SKIP : I2C_ACK;
        default: ;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      scl_d_reg <= 1'b1; sda_d_reg <= 1'b1; st_reg <= I2C_IDLE; ret_reg <= I2C_IDLE;
      sh_reg <= 8'h00; wa_reg <= 8'h00; tx_reg <= 8'h00; bit_reg <= 4'h0;
      ack_reg <= 1'b0; sda_oe_reg <= 1'b0; rd_reg <= 1'b0; dev_addr_reg <= DEV_ADDR_RESET;
    end else begin
      scl_d_reg <= i_scl; sda_d_reg <= i_sda; st_reg <= st_next; ret_reg <= ret_next;
      sh_reg <= sh_next; wa_reg <= wa_next; tx_reg <= tx_next; bit_reg <= bit_next;
      ack_reg <= ack_next; sda_oe_reg <= sda_oe_next; rd_reg <= rd_next;
    end
  end
  assign o_sda_o  = 1'b0;
  assign o_sda_oe = sda_oe_reg;

  // Sequencer, dwell counter, phase splitter, row ring
  logic [15:0] cnt_reg, cnt_next;
  logic        ph_reg, ph_next;
  logic [2:0]  state_reg, state_next;
  logic [7:0]  ring_reg, ring_next;
  logic [6:0]  col_reg, col_next;
  logic        fresh_reg, fresh_next;
  logic [7:0]  en;
  logic        step;

  assign req = '{we: we, waddr: slot_of(wa_reg), wdata: sh_reg, raddr: slot_of(wa_reg)};

  lmrs_pattern_mem #(.DEPTH(NUM_ROWS)) u_mem (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .i_req     (req),
    .i_raddr2  (state_reg),
    .o_rdata   (mem_rdata),
    .o_rdata2  (pat_rdata)
  );

  genvar g;
  generate
    for (g = 0; g < NUM_ROWS; g++) begin : g_en
      assign en[g] = (g % 2 == 1) ? ph_reg : ~ph_reg;
    end
  endgenerate

  always_comb begin
    cnt_next = cnt_reg + 16'h1; ph_next = ph_reg; step = 1'b0;
    state_next = state_reg; ring_next = ring_reg; col_next = col_reg;
    if (cnt_reg == 16'(DWELL_CYCLES - 1)) begin
      cnt_next = 16'h0;
      ph_next = ~ph_reg;
    end
    // Level enables: only one phase per state can ever satisfy the test
    if (en[3'(state_reg + 3'h1)] && !en[state_reg] && ph_next == ph_reg) begin
      step = 1'b1;
      state_next = state_reg + 3'h1;
      ring_next = {ring_reg[6:0], ring_reg[7]};
    end
    col_next = pat_rdata[6:0];
    if (!i_sequencer_reset_n) begin
      state_next = 3'h0; ring_next = RING_RESET; cnt_next = 16'h0; ph_next = 1'b0;
    end
  end
  assign fresh_next = step;

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      cnt_reg <= 16'h0; ph_reg <= 1'b0; state_reg <= 3'h0;
      ring_reg <= RING_RESET;
      col_reg <= 7'h00; fresh_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next; ph_reg <= ph_next; state_reg <= state_next;
      ring_reg <= ring_next; col_reg <= col_next; fresh_reg <= fresh_next;
    end
  end
  assign o_col   = col_reg;
  assign o_row_n = ring_reg;

  property p_one_low;
    @(posedge i_clk) disable iff (i_sys_rst) $countones(~ring_reg) == 1;
  endproperty
  a_one_low: assert property (p_one_low) else $error("ring not one-hot low");

  property p_lockstep;
    @(posedge i_clk) disable iff (i_sys_rst) ring_reg == ~(8'h01 << state_reg);
  endproperty
  a_lockstep: assert property (p_lockstep) else $error("row not matching state");

  property p_rotate;
    @(posedge i_clk) disable iff (i_sys_rst || !i_sequencer_reset_n)
      step |=> ring_reg == {$past(ring_reg[6:0]), $past(ring_reg[7])};
  endproperty
  a_rotate: assert property (p_rotate) else $error("ring did not rotate");

  property p_dwell;
    @(posedge i_clk) disable iff (i_sys_rst || !i_sequencer_reset_n)
      step |=> !step [*8];
  endproperty
  a_dwell: assert property (p_dwell) else $error("state skipped early");

  property p_advance;
    @(posedge i_clk) disable iff (i_sys_rst || !i_sequencer_reset_n)
      step |=> state_reg == 3'($past(state_reg) + 3'h1);
  endproperty
  a_advance: assert property (p_advance) else $error("bad state step");

  property p_phase_edge;
    @(posedge i_clk) disable iff (i_sys_rst || !i_sequencer_reset_n)
      step |-> cnt_reg == 16'h0;
  endproperty
  a_phase_edge: assert property (p_phase_edge) else $error("step off phase edge");

  property p_seq_reset;
    @(posedge i_clk) disable iff (i_sys_rst)
      !i_sequencer_reset_n |=> state_reg == 3'h0 && ring_reg == RING_RESET;
  endproperty
  a_seq_reset: assert property (p_seq_reset) else $error("reset not to state 0");

  property p_cols;
    @(posedge i_clk) disable iff (i_sys_rst) fresh_reg |-> ##2 o_col[6:0] == $past(pat_rdata[6:0]);
  endproperty
  a_cols: assert property (p_cols) else $error("columns not pattern");
endmodule : lmrs_scanner

/* File: lmrs_i2c_master.sv */
`timescale 1ns/1ns
module lmrs_i2c_master (
  input  wire logic i_clk,
  input  wire logic i_sda,
  output logic      o_scl,
  output logic      o_sda_pull
);
  initial begin
    o_scl      = 1'b1;
    o_sda_pull = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask : tick
  // Half periods of 5 clk keep clear of the 4 clk minimum of the device
  task automatic bit_io(input logic b, output logic s);
    o_scl = 1'b0;
    tick(2);
    o_sda_pull = ~b;
    tick(3);
    o_scl = 1'b1;
    tick(3);
    s = i_sda;
    tick(2);
  endtask : bit_io
  // Also serves as repeated start, as it begins by pulling SCL low before releasing SDA
  task automatic start_cond();
    o_scl = 1'b0;
    tick(2);
    o_sda_pull = 1'b0;
    tick(3);
    o_scl = 1'b1;
    tick(5);
    o_sda_pull = 1'b1;
    tick(5);
  endtask : start_cond
  task automatic stop_cond();
    o_scl = 1'b0;
    tick(2);
    o_sda_pull = 1'b1;
    tick(3);
    o_scl = 1'b1;
    tick(5);
    o_sda_pull = 1'b0;
    tick(5);
  endtask : stop_cond
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], s);
    end
    bit_io(1'b1, s);
    ack = ~s;
  endtask : send_byte
  task automatic read_byte(output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, s);
      d[i] = s;
    end
    bit_io(1'b1, s);
  endtask : read_byte
endmodule : lmrs_i2c_master

/* File: tb.sv */
`timescale 1ns/1ns
module tb;
  import lmrs_pkg::*;
  logic       i_clk = 1'b0;
  logic       i_sys_rst = 1'b1;
  logic       i_sequencer_reset_n = 1'b1;
  logic       scl;
  logic       sda_pull;
  logic       o_sda_o;
  logic       o_sda_oe;
  logic [6:0] o_col;
  logic [7:0] o_row_n;
  logic [7:0] exp_pat [8];
  int         miscompares = 0;
  int         num_checks = 0;
  // Pull-up on SDA: any party driving low wins
  wire logic  sda = ~(sda_pull | (o_sda_oe & ~o_sda_o));
  always #20 i_clk = ~i_clk;
  lmrs_scanner lmrs_scanner_inst (.i_clk, .i_sys_rst, .i_sequencer_reset_n, .i_scl(scl),
    .i_sda(sda), .o_sda_o, .o_sda_oe, .o_col, .o_row_n);
  lmrs_i2c_master lmrs_i2c_master_inst (.i_clk, .i_sda(sda), .o_scl(scl), .o_sda_pull(sda_pull));
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask : tick
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : test_done
  task automatic wr(input logic [7:0] ctl, word, data, input logic [2:0] exp_ack);
    logic [2:0] a;
    lmrs_i2c_master_inst.start_cond();
    lmrs_i2c_master_inst.send_byte(ctl, a[2]);
    lmrs_i2c_master_inst.send_byte(word, a[1]);
    lmrs_i2c_master_inst.send_byte(data, a[0]);
    lmrs_i2c_master_inst.stop_cond();
    chk("ack", 16'(a), 16'(exp_ack));
  endtask : wr
  task automatic rd(input logic [7:0] word, exp);
    logic [2:0] a;
    logic [7:0] d;
    lmrs_i2c_master_inst.start_cond();
    lmrs_i2c_master_inst.send_byte(8'h00, a[2]);
    lmrs_i2c_master_inst.send_byte(word, a[1]);
    lmrs_i2c_master_inst.start_cond();
    lmrs_i2c_master_inst.send_byte(8'h01, a[0]);
    lmrs_i2c_master_inst.read_byte(d);
    lmrs_i2c_master_inst.stop_cond();
    chk("read", {5'h00, a, d}, {8'h07, exp});
  endtask : rd
  task automatic wait_step(output int n);
    logic [7:0] prev;
    prev = o_row_n;
    n = 0;
    while (o_row_n === prev) begin
      tick(1);
      n++;
      if (n > DWELL_CYCLES + 100) begin
        miscompares++;
        $display("[ERR] row step expected change seen none");
        test_done();
      end
    end
  endtask : wait_step
  task automatic test_reset();
    chk("row", 16'(o_row_n), 16'h00FE);
    chk("sda_oe", 16'(o_sda_oe), 16'h0000);
    chk("col", 16'(o_col), 16'(exp_pat[0][6:0]));
    $display("test reset done");
  endtask : test_reset
  task automatic test_bus();
    wr(8'h00, PATTERN_BASE + 8'h03, 8'h7F, 3'b111);
    exp_pat[3] = 8'h7F;
    wr(8'h00, PATTERN_BASE + 8'h06, 8'hAA, 3'b111);
    exp_pat[6] = 8'hAA;
    wr(8'h10, PATTERN_BASE + 8'h05, 8'h55, 3'b000);
    wr(8'h02, PATTERN_BASE + 8'h05, 8'h55, 3'b000);
    wr(8'h00, 8'hE0, 8'h33, 3'b111);
    rd(PATTERN_BASE + 8'h03, 8'h7F);
    rd(PATTERN_BASE + 8'h05, exp_pat[5]);
    rd(8'hE0, 8'h00);
    $display("test bus done");
  endtask : test_bus
  task automatic test_seq_reset();
    int n;
    wait_step(n);
    i_sequencer_reset_n = 1'b0;
    tick(3);
    chk("row", 16'(o_row_n), 16'h00FE);
    i_sequencer_reset_n = 1'b1;
    tick(3);
    chk("col", 16'(o_col), 16'(exp_pat[0][6:0]));
    $display("test sequencer reset done");
  endtask : test_seq_reset
  // A full lap from state 0 back to state 0
  task automatic test_scan();
    logic [7:0] er;
    int         n;
    er = 8'hFE;
    for (int i = 0; i < 8; i++) begin
      wait_step(n);
      er = {er[6:0], er[7]};
      chk("row", 16'(o_row_n), 16'(er));
      if (i > 0) begin
        chk("dwell", 16'(n + 2), 16'(DWELL_CYCLES));
      end
      tick(2);
      chk("col", 16'(o_col), 16'(exp_pat[(i + 1) % 8][6:0]));
    end
    $display("test scan done");
  endtask : test_scan
  initial begin
    for (int n = 0; n < 8; n++) begin
      exp_pat[n] = INIT_CHARACTER[8 * n +: 8];
    end
    tick(3);
    i_sys_rst = 1'b0;
    tick(3);
    test_reset();
    test_bus();
    test_seq_reset();
    test_scan();
    test_done();
  end
endmodule : tb
